// File: verilog/psel_defs.svh
// register offsets, field positions, reset values, selector codes and timing for the
// phy status event and indicator select block.
// assumes: included by bare name from the package and from the psel_led_drive and psel_event_led modules.
`ifndef PSEL_DEFS_SVH
`define PSEL_DEFS_SVH

// register offsets on the management register port
`define PSEL_REG_MASK 5'h12
`define PSEL_REG_FLAGS 5'h13
`define PSEL_REG_LED 5'h14

// event field positions inside the mask and flag registers
`define PSEL_EV_LSB 4
`define PSEL_EV_MSB 7
`define PSEL_EV_AN 3
`define PSEL_EV_SPEED 2
`define PSEL_EV_DUPLEX 1
`define PSEL_EV_LINK 0

// indicator select register fields
`define PSEL_SEL1_MSB 15
`define PSEL_SEL1_LSB 12
`define PSEL_SEL2_MSB 11
`define PSEL_SEL2_LSB 8
`define PSEL_STRETCH_BIT 1

// reset values
`define PSEL_MASK_RST 4'h0
`define PSEL_FLAGS_RST 4'h0
`define PSEL_SEL1_RST 4'h0
`define PSEL_SEL2_RST 4'h4
`define PSEL_STRETCH_RST 1'b1

// selector codes
`define PSEL_C_SPEED 4'h0
`define PSEL_C_TX 4'h1
`define PSEL_C_RX 4'h2
`define PSEL_C_COL 4'h3
`define PSEL_C_LINK 4'h4
`define PSEL_C_DUPLEX 4'h5
`define PSEL_C_UNUSED 4'h6
`define PSEL_C_ACT 4'h7
`define PSEL_C_ON 4'h8
`define PSEL_C_OFF 4'h9
`define PSEL_C_FAST 4'ha
`define PSEL_C_SLOW 4'hb
`define PSEL_C_LINK_RX 4'hc
`define PSEL_C_COMB_D 4'hd
`define PSEL_C_COMB_E 4'he

// activity source index
`define PSEL_A_TX 0
`define PSEL_A_RX 1
`define PSEL_A_COL 2
`define PSEL_A_ANY 3

// timing
`define PSEL_CLK_PERIOD_NS 10
`define PSEL_TICK_PERIOD_NS 1000000
`define PSEL_TICK_CYCLES (`PSEL_TICK_PERIOD_NS / `PSEL_CLK_PERIOD_NS)
`define PSEL_STRETCH_MS 30
`define PSEL_FAST_HALF_MS 50
`define PSEL_SLOW_HALF_MS 250

`endif

// File: verilog/psel_pkg.sv
// state types of the phy status event and indicator select block.
// assumes: psel_defs.svh is on the include path.
`include "psel_defs.svh"

package psel_pkg;

    typedef struct packed {
        logic [3:0] mask;
        logic [3:0] flags;
        logic [3:0] sel1;
        logic [3:0] sel2;
        logic stretch_en;
        logic [3:0] prev;
        logic [15:0] rdata;
        logic rvalid;
        logic [16:0] tick_cnt;
        logic tick;
        logic [3:0][7:0] str_cnt;
        logic [7:0] fast_cnt;
        logic [8:0] slow_cnt;
        logic fast_ph;
        logic slow_ph;
        logic irq;
    } psel_state_t;

    typedef struct packed {
        logic led;
    } psel_led_state_t;

endpackage

// File: verilog/psel_led_if.sv
// indicator sources shared by the event block and its indicator drivers.
// assumes: one source, any number of sinks, all on sys_clk_in.
`timescale 1ns/100ps
`default_nettype none

interface psel_led_if;
    logic link;
    logic duplex;
    logic speed;
    logic [3:0] raw;
    logic [3:0] stretched;
    logic fast_blink;
    logic slow_blink;
    logic stretch_en;

    modport src (
        output link,
        output duplex,
        output speed,
        output raw,
        output stretched,
        output fast_blink,
        output slow_blink,
        output stretch_en
    );

    modport sink (
        input link,
        input duplex,
        input speed,
        input raw,
        input stretched,
        input fast_blink,
        input slow_blink,
        input stretch_en
    );
endinterface

`default_nettype wire

// File: verilog/psel_led_drive.sv
// one indicator driver: maps a 4-bit selector code onto a registered led level.
// assumes: sources arrive through psel_led_if on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "psel_defs.svh"

module psel_led_drive
    import psel_pkg::*;
#(
    parameter bit SECOND = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    psel_led_if.sink src,
    input wire logic [3:0] sel_in,
    output logic led_out
);

    psel_led_state_t st;
    psel_led_state_t next_st;
    logic [3:0] shown;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        // stretch enable only governs the single-source activity codes
        shown = src.stretch_en ? src.stretched : src.raw;
        case (sel_in)
            `PSEL_C_SPEED: next_st.led = src.speed;
            `PSEL_C_TX: next_st.led = shown[`PSEL_A_TX];
            `PSEL_C_RX: next_st.led = shown[`PSEL_A_RX];
            `PSEL_C_COL: next_st.led = shown[`PSEL_A_COL];
            `PSEL_C_LINK: next_st.led = src.link;
            `PSEL_C_DUPLEX: next_st.led = src.duplex;
            `PSEL_C_ACT: next_st.led = shown[`PSEL_A_ANY];
            `PSEL_C_ON: next_st.led = 1'b1;
            `PSEL_C_OFF: next_st.led = 1'b0;
            `PSEL_C_FAST: next_st.led = src.fast_blink;
            `PSEL_C_SLOW: next_st.led = src.slow_blink;
            `PSEL_C_LINK_RX: begin
                next_st.led = src.link ^ (src.stretched[`PSEL_A_RX] & src.fast_blink);
            end
            `PSEL_C_COMB_D: begin
                if (SECOND) begin
                    // activity blinks the led whether the link is up or down
                    next_st.led = src.link ^ (src.stretched[`PSEL_A_ANY] & src.fast_blink);
                end else begin
                    next_st.led = src.duplex ^ (src.stretched[`PSEL_A_COL] & src.fast_blink);
                end
            end
            `PSEL_C_COMB_E: begin
                if (SECOND) begin
                    next_st.led = src.duplex ^ (src.stretched[`PSEL_A_COL] & src.fast_blink);
                end else begin
                    next_st.led = 1'b0;
                end
            end
            default: next_st.led = 1'b0; // unassigned codes keep the led dark
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign led_out = st.led;

endmodule

`default_nettype wire

// File: verilog/psel_event_led.sv
// status-change event flags, interrupt mask and indicator source selection.
// assumes: the management frame decoder presents single-cycle register reads and
// writes on reg_*; phy status inputs are synchronous to sys_clk_in.
//
// How it works
// - autoneg done interrupts only when mask 18.7
// - speed change interrupts only when mask 18.6
// - duplex change interrupts only when mask 18.5
// - link change interrupts only when mask 18.4
// - 19.7 reports autoneg completion, cleared by read
// - 19.6 latches speed change until register read
// - 19.5 latches duplex change until register read
// - 19.4 latches link change until register read
// - first selector resets speed; link, duplex codes
// - transmit, receive, collision, activity codes are stretched
// - test codes: on, off, fast, slow blink
// - code 1100: link solid, receive blinks
// - first 1101: full duplex solid, collision blinks
// - combined codes always stretched, ignore enable bit
// - second selector resets to link status
// - second 1101: link solid, activity blinks
// - activity toggles led regardless of link
`timescale 1ns/100ps
`default_nettype none
`include "psel_defs.svh"

module psel_event_led
    import psel_pkg::*;
#(
    parameter int TICK_CYCLES = `PSEL_TICK_CYCLES,
    parameter int STRETCH_MS = `PSEL_STRETCH_MS,
    parameter int FAST_HALF_MS = `PSEL_FAST_HALF_MS,
    parameter int SLOW_HALF_MS = `PSEL_SLOW_HALF_MS
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic speed_100_in,
    input wire logic full_duplex_in,
    input wire logic link_up_in,
    input wire logic autoneg_done_in,
    input wire logic tx_active_in,
    input wire logic rx_active_in,
    input wire logic collision_in,
    output logic irq_out,
    output logic [1:0] led_out
);

    psel_state_t st;
    psel_state_t next_st;
    logic [3:0] events;
    logic [3:0] raw_act;
    logic [3:0] status_now;
    logic flags_read;
    logic wr_mask;
    logic wr_led;
    logic [3:0][7:0] str_next;
    logic [3:0] stretched;

    psel_led_if ind ();

    ////////////////////////////////////////////////////////////////////////////
    // event detection
    assign status_now = {autoneg_done_in, speed_100_in, full_duplex_in, link_up_in};
    assign raw_act = {tx_active_in | rx_active_in, collision_in, rx_active_in, tx_active_in};

    always_comb begin
        events = '0;
        // completion latches on the rising edge only
        events[`PSEL_EV_AN] = status_now[`PSEL_EV_AN] & ~st.prev[`PSEL_EV_AN];
        events[`PSEL_EV_SPEED] = status_now[`PSEL_EV_SPEED] ^ st.prev[`PSEL_EV_SPEED];
        events[`PSEL_EV_DUPLEX] = status_now[`PSEL_EV_DUPLEX] ^ st.prev[`PSEL_EV_DUPLEX];
        events[`PSEL_EV_LINK] = status_now[`PSEL_EV_LINK] ^ st.prev[`PSEL_EV_LINK];
    end

    assign flags_read = reg_rd_in && (reg_addr_in == `PSEL_REG_FLAGS);
    assign wr_mask = reg_wr_in && (reg_addr_in == `PSEL_REG_MASK);
    assign wr_led = reg_wr_in && (reg_addr_in == `PSEL_REG_LED);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_st.prev = status_now;

        // a read clears the flags, but an event in the same cycle survives it
        next_st.flags = (st.flags & ~{4{flags_read}}) | events;

        if (wr_mask) begin
            // unused mask bits are not stored and read back as zero
            next_st.mask = reg_wdata_in[`PSEL_EV_MSB:`PSEL_EV_LSB];
        end
        if (wr_led) begin
            next_st.sel1 = reg_wdata_in[`PSEL_SEL1_MSB:`PSEL_SEL1_LSB];
            next_st.sel2 = reg_wdata_in[`PSEL_SEL2_MSB:`PSEL_SEL2_LSB];
            next_st.stretch_en = reg_wdata_in[`PSEL_STRETCH_BIT];
        end

        // read data holds its value until the next read
        next_st.rvalid = reg_rd_in;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `PSEL_REG_MASK: begin
                    next_st.rdata = {8'h00, st.mask, 4'h0};
                end
                `PSEL_REG_FLAGS: begin
                    // returns the flags as they were before this read cleared them
                    next_st.rdata = {8'h00, st.flags, 4'h0};
                end
                `PSEL_REG_LED: begin
                    next_st.rdata = {st.sel1, st.sel2, 6'h00, st.stretch_en, 1'b0};
                end
                default: next_st.rdata = 16'h0000;
            endcase
        end

        // millisecond tick from the core clock
        if (st.tick_cnt == 17'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 17'h00001;
            next_st.tick = 1'b0;
        end

        next_st.str_cnt = str_next;

        // blink generators for test and combined codes
        if (st.tick) begin
            if (st.fast_cnt >= 8'(FAST_HALF_MS - 1)) begin
                next_st.fast_cnt = '0;
                next_st.fast_ph = ~st.fast_ph;
            end else begin
                next_st.fast_cnt = st.fast_cnt + 8'h01;
            end
            if (st.slow_cnt >= 9'(SLOW_HALF_MS - 1)) begin
                next_st.slow_cnt = '0;
                next_st.slow_ph = ~st.slow_ph;
            end else begin
                next_st.slow_cnt = st.slow_cnt + 9'h001;
            end
        end

        // request follows the flags after this cycle's set and clear
        next_st.irq = |(next_st.flags & next_st.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            st <= '0;
            st.mask <= `PSEL_MASK_RST;
            st.flags <= `PSEL_FLAGS_RST;
            st.sel1 <= `PSEL_SEL1_RST;
            st.sel2 <= `PSEL_SEL2_RST;
            st.stretch_en <= `PSEL_STRETCH_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // indicator sources
    // activity stretchers: any activity restarts the hold time, ticks run it down
    genvar a;
    generate
        for (a = 0; a < 4; a++) begin : gen_stretch
            assign str_next[a] = raw_act[a] ? 8'(STRETCH_MS) :
                (st.tick && (st.str_cnt[a] != 8'h00)) ? st.str_cnt[a] - 8'h01 :
                st.str_cnt[a];
            assign stretched[a] = raw_act[a] | (st.str_cnt[a] != 8'h00);
        end
    endgenerate

    assign ind.stretched = stretched;

    assign ind.link = link_up_in;
    assign ind.duplex = full_duplex_in;
    assign ind.speed = speed_100_in;
    assign ind.raw = raw_act;
    assign ind.fast_blink = st.fast_ph;
    assign ind.slow_blink = st.slow_ph;
    assign ind.stretch_en = st.stretch_en;

    // code 0110 is never expected; the drivers keep the led dark on it
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_led
            psel_led_drive #(
                .SECOND(g == 1)
            ) u_drive (
                .sys_clk_in(sys_clk_in),
                .rst_b_in(rst_b_in),
                .src(ind),
                .sel_in((g == 0) ? st.sel1 : st.sel2),
                .led_out(led_out[g])
            );
        end
    endgenerate

    assign reg_rdata_out = st.rdata;
    assign reg_rvalid_out = st.rvalid;
    assign irq_out = st.irq;

endmodule

`default_nettype wire

// File: dv/psel_event_led_assertions.sv
// checker: register answers, change flags and interrupt request at the block ports.
// assumes: bound onto psel_event_led; one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module psel_event_led_assertions (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic speed_100_in,
    input wire logic full_duplex_in,
    input wire logic link_up_in,
    input wire logic autoneg_done_in,
    input wire logic irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////
    sequence flags_rd_s;
        reg_rd_in && reg_addr_in == 5'h13;
    endsequence
    // history restarts at release, so the first edge after it is skipped
    sequence quiet_s;
        $past(rst_b_in) && !$changed(speed_100_in) && !$changed(full_duplex_in)
            && !$changed(link_up_in) && !$rose(autoneg_done_in);
    endsequence
    property flag_p(ev, int b);
        ($past(rst_b_in) && ev) ##1 flags_rd_s |=> reg_rdata_out[b];
    endproperty

    an_flag_a: assert property (flag_p($rose(autoneg_done_in), 7))
        else $error("autoneg flag missing");
    speed_flag_a: assert property (flag_p($changed(speed_100_in), 6))
        else $error("speed flag missing");
    duplex_flag_a: assert property (flag_p($changed(full_duplex_in), 5))
        else $error("duplex flag missing");
    link_flag_a: assert property (flag_p($changed(link_up_in), 4))
        else $error("link flag missing");
    flag_clear_a: assert property ((flags_rd_s and quiet_s) ##1
        (flags_rd_s and quiet_s) |=> reg_rdata_out[7:4] == 4'h0)
        else $error("flags not cleared by read");
    irq_release_a: assert property ((flags_rd_s and quiet_s) |=> !irq_out)
        else $error("irq held after read");
    mask_block_a: assert property (reg_wr_in && reg_addr_in == 5'h12
        && reg_wdata_in[7:4] == 4'h0 |=> !irq_out)
        else $error("irq with all masks off");
    rst_idle_a: assert property (disable iff (1'b0) !rst_b_in |=> !irq_out)
        else $error("irq during reset");
endmodule

bind psel_event_led psel_event_led_assertions u_psel_event_led_assertions (
    .sys_clk_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
    .reg_rdata_out, .speed_100_in, .full_duplex_in, .link_up_in, .autoneg_done_in, .irq_out
);
`default_nettype wire

// File: dv/psel_station.sv
// management station model driving the register strobes of the block.
// assumes: tasks called 1 ns after a clock edge; strobes held until idle().
`timescale 1ns/100ps
`default_nettype none

module psel_station (
    input wire logic sys_clk_in,
    input wire logic [15:0] reg_rdata_in,
    output logic [4:0] reg_addr_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [15:0] reg_wdata_out
);
    initial begin
        reg_addr_out = 5'h00;
        reg_wdata_out = 16'h0000;
        idle();
    end
    ////////////////////////////////////////
    function automatic logic [15:0] used(input logic [4:0] a);
        return (a == 5'h14) ? 16'hff02 : (a == 5'h12 || a == 5'h13) ? 16'h00f0 : 16'hffff;
    endfunction
    task automatic idle();
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        // the unused code 0110 is never sent
        if (a == 5'h14 && (d[15:12] == 4'h6 || d[11:8] == 4'h6)) begin
            return;
        end
        reg_addr_out = a;
        reg_wdata_out = d & used(a);
        reg_rd_out = 1'b0;
        reg_wr_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        reg_addr_out = a;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        d = reg_rdata_in & used(a);
    endtask
endmodule
`default_nettype wire

// File: dv/psel_event_led_tb.sv
// testbench: random events and masks, indicator codes, stretch and blink timing.
// assumes: psel_station drives the register port; long counts scaled down.
`timescale 1ns/100ps
`default_nettype none

module psel_event_led_tb;
    localparam int TK = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic spd = 1'b0, dup = 1'b0, lnk = 1'b0, an = 1'b0, tx = 1'b0, rx = 1'b0, col = 1'b0;
    logic [4:0] addr;
    logic wr, rd, irq, rvalid;
    logic [15:0] wdata, rdata;
    logic [1:0] led;
    logic [31:0] seed = 32'h6965;
    int err_count = 0;
    int n_tests = 0;

    psel_event_led #(.TICK_CYCLES(TK), .STRETCH_MS(2), .FAST_HALF_MS(2), .SLOW_HALF_MS(4))
    u_psel_event_led (
        .sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .speed_100_in(spd), .full_duplex_in(dup), .link_up_in(lnk), .autoneg_done_in(an),
        .tx_active_in(tx), .rx_active_in(rx), .collision_in(col), .irq_out(irq), .led_out(led)
    );
    psel_station u_psel_station (
        .sys_clk_in(clk), .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_wdata_out(wdata)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // steady level expected once stretch has run out and no activity is present
    function automatic logic exp_led(input logic [3:0] c, input logic sec);
        case (c)
            4'h0: return spd;
            4'h4, 4'hc: return lnk;
            4'h5: return dup;
            4'h8: return 1'b1;
            4'hd: return sec ? lnk : dup;
            4'he: return sec ? dup : 1'b0;
            default: return 1'b0;
        endcase
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic watch(input int n, input int b, output int ones, output int tog);
        logic last;
        ones = 0;
        tog = 0;
        last = led[b];
        repeat (n) begin
            step(1);
            ones += int'(led[b] === 1'b1);
            tog += int'(led[b] !== last);
            last = led[b];
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_count++;
        close_out();
    end
    initial begin
        logic [15:0] d;
        logic [7:0] r;
        logic [3:0] fl;
        int ones, tog;
        step(6);
        rst_b = 1'b1;
        u_psel_station.rd(5'h12, d);
        check("mask reset", d, 16'h0000);
        check("read valid", 16'(rvalid), 16'h0001);
        u_psel_station.rd(5'h14, d);
        check("select reset", d, 16'h0402);
        u_psel_station.rd(5'h1f, d);
        check("unmapped read", d, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            // first pass is the corner: all events at once, all unmasked
            r = (i == 0) ? 8'hff : seed[7:0];
            u_psel_station.wr(5'h12, {8'h00, r[3:0], 4'h0});
            u_psel_station.rd(5'h12, d);
            check("mask readback", d, {8'h00, r[3:0], 4'h0});
            u_psel_station.idle();
            fl = {r[7] & ~an, r[6:4]};
            an = an ^ r[7];
            spd = spd ^ r[6];
            dup = dup ^ r[5];
            lnk = lnk ^ r[4];
            step(1);
            check("irq raise", 16'(irq), 16'(|(fl & r[3:0])));
            u_psel_station.rd(5'h13, d);
            check("flags", d, {8'h00, fl, 4'h0});
            u_psel_station.rd(5'h13, d);
            check("flags cleared", d, 16'h0000);
            u_psel_station.idle();
            step(1);
            check("irq release", 16'(irq), 16'h0000);
            check("read valid end", 16'(rvalid), 16'h0000);
        end
        u_psel_station.wr(5'h12, 16'h0000);
        for (int c = 0; c < 16; c++) begin
            if (c == 6 || c == 10 || c == 11) begin
                continue;
            end
            u_psel_station.wr(5'h14, {c[3:0], c[3:0], 8'h02});
            u_psel_station.idle();
            seed = lfsr(seed);
            {spd, dup, lnk} = seed[2:0];
            step(30);
            check("first led", 16'(led[0]), 16'(exp_led(c[3:0], 1'b0)));
            check("second led", 16'(led[1]), 16'(exp_led(c[3:0], 1'b1)));
        end
        u_psel_station.wr(5'h14, 16'h1702);
        u_psel_station.idle();
        tx = 1'b1;
        step(1);
        tx = 1'b0;
        step(3);
        check("stretch on", 16'(led), 16'h0003);
        step(20);
        check("stretch off", 16'(led), 16'h0000);
        u_psel_station.wr(5'h14, 16'h2302);
        u_psel_station.idle();
        col = 1'b1;
        step(1);
        col = 1'b0;
        step(3);
        check("collision stretch", 16'(led), 16'h0002);
        step(20);
        // stretch enable cleared: single-source codes follow the raw activity
        u_psel_station.wr(5'h14, 16'h2300);
        u_psel_station.idle();
        rx = 1'b1;
        step(1);
        rx = 1'b0;
        step(3);
        check("raw receive", 16'(led), 16'h0000);
        // stretch enable cleared: combined codes must still blink
        u_psel_station.wr(5'h14, 16'hcd00);
        u_psel_station.idle();
        lnk = 1'b0;
        rx = 1'b1;
        watch(40, 1, ones, tog);
        check("link act blink", 16'(ones > 0), 16'h0001);
        watch(40, 0, ones, tog);
        check("link rx blink", 16'(ones > 0), 16'h0001);
        // second led shows the fast phase; a short receive pulse lands inside its high half
        u_psel_station.wr(5'h14, 16'hca00);
        u_psel_station.idle();
        rx = 1'b0;
        step(12);
        for (int k = 0; k < 20 && led[1] !== 1'b0; k++) begin
            step(1);
        end
        for (int k = 0; k < 20 && led[1] !== 1'b1; k++) begin
            step(1);
        end
        rx = 1'b1;
        step(1);
        rx = 1'b0;
        step(3);
        check("combined stretch", 16'(led), 16'h0003);
        u_psel_station.wr(5'h14, 16'hd000);
        u_psel_station.idle();
        rx = 1'b0;
        dup = 1'b1;
        col = 1'b1;
        watch(40, 0, ones, tog);
        check("duplex col blink", 16'(ones > 0 && ones < 40), 16'h0001);
        u_psel_station.wr(5'h14, 16'hab02);
        u_psel_station.idle();
        col = 1'b0;
        step(4);
        watch(128, 0, ones, tog);
        check("fast toggles", 16'(tog), 16'(128 / (2 * TK)));
        watch(128, 1, ones, tog);
        check("slow toggles", 16'(tog), 16'(128 / (4 * TK)));
        close_out();
    end
endmodule
`default_nettype wire
